//--- smc_defines.svh
// register map, field positions, reset values and counts of the spi controller
// included by the package users; definitions only
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// byte offsets on the register bus
`define SMC_OFS_CTL      4'h0
`define SMC_OFS_CFG      4'h4
`define SMC_OFS_DAT      4'h8
`define SMC_OFS_DIV      4'hC

// serial_control_reg fields
`define SMC_CTL_DONE     7
`define SMC_CTL_WRITE_COLLISION_FLAG     6
`define SMC_CTL_MODE_FAULT_FLAG     5
`define SMC_CTL_OVRN     4
`define SMC_CTL_SEL_HI   3
`define SMC_CTL_SEL_LO   2
`define SMC_CTL_TXBMT    1
`define SMC_CTL_EN       0

// configuration register fields
`define SMC_CFG_BUSY     7
`define SMC_CFG_MST      6
`define SMC_CFG_PHA      5
`define SMC_CFG_POL      4
`define SMC_CFG_SLVSEL   3
`define SMC_CFG_NSSIN    2
`define SMC_CFG_SRMT     1
`define SMC_CFG_RXBMT    0

// reset values
`define SMC_RST_SEL      2'h1
`define SMC_RST_DIV      8'h00
`define SMC_RST_RDATA    32'h0000_0000

// index of the last bit of a byte and clock half periods per byte
`define SMC_LAST_BIT     4'h7
`define SMC_HALF_EDGES   5'h10

`endif

//--- smc_pkg.sv
// types shared by the spi controller top and its clock generator
// no assumptions beyond the defines header
package smc_pkg;
  typedef logic [7:0] smc_byte_t;
  typedef enum logic [1:0] {
    SMC_SEL_3WIRE  = 2'b00,
    SMC_SEL_4W_IN  = 2'b01,
    SMC_SEL_OUT_LO = 2'b10,
    SMC_SEL_OUT_HI = 2'b11
  } smc_sel_t;
endpackage : smc_pkg

//--- smc_gen_if.sv
// carrier between the controller top and the master serial clock generator
// both ends run on core_clk
`timescale 1ns/1ns
interface smc_gen_if;
  logic              start;
  logic              abort;
  smc_pkg::smc_byte_t div;
  logic              cpol;
  logic              cpha;
  logic              sck;
  logic              busy;
  logic              shift_stb;
  logic              done_stb;
  modport ctl (output start, abort, div, cpol, cpha,
               input  sck, busy, shift_stb, done_stb);
  modport gen (input  start, abort, div, cpol, cpha,
               output sck, busy, shift_stb, done_stb);
endinterface : smc_gen_if

//--- smc_sck_gen.sv
// master serial clock generator: half period of div+1 core clocks
// assumes start arrives only while idle and abort drops it at once
`timescale 1ns/1ns
`include "smc_defines.svh"
module smc_sck_gen (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // controller side
  smc_gen_if.gen   g
);
  import smc_pkg::*;

  logic [7:0] cnt_r;
  logic [4:0] edge_r;
  logic       run_r;
  logic       sck_r;

  wire        tick      = run_r & (cnt_r == g.div);
  wire [4:0]  edge_nxt  = edge_r + 5'h01;
  // phase 1 needs one more half period so the last bit is taken late
  wire [4:0]  last_edge = g.cpha ? (`SMC_HALF_EDGES + 5'h01) : `SMC_HALF_EDGES;
  wire        shift_pt  = g.cpha ? (edge_nxt[0] & (edge_nxt >= 5'h03))
                                 : ~edge_nxt[0];
  wire        toggle    = edge_nxt <= `SMC_HALF_EDGES;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      run_r  <= 1'b0;
      cnt_r  <= 8'h00;
      edge_r <= 5'h00;
      sck_r  <= 1'b0;
    end else if (g.abort) begin
      run_r  <= 1'b0;
      cnt_r  <= 8'h00;
      edge_r <= 5'h00;
      sck_r  <= g.cpol;                              // R22
    end else if (!run_r) begin
      run_r  <= g.start;
      cnt_r  <= 8'h00;
      edge_r <= 5'h00;
      sck_r  <= g.cpol;                              // R22
    end else begin
      cnt_r <= tick ? 8'h00 : cnt_r + 8'h01;         // R23
      if (tick) begin
        edge_r <= edge_nxt;
        if (toggle) begin
          sck_r <= ~sck_r;
        end
        if (edge_nxt == last_edge) begin
          run_r <= 1'b0;
        end
      end
    end
  end

  assign g.sck       = sck_r;
  assign g.busy      = run_r;
  assign g.shift_stb = tick & shift_pt;              // R22
  assign g.done_stb  = tick & (edge_nxt == last_edge);
endmodule : smc_sck_gen

//--- smc_spi_ctrl.sv
// spi master/slave controller with avalon-mm register slave
// pins are sampled as synchronous to core_clk; pads resolve the enables
//
// Function
// [R1] miso not driven when disabled or when unselected four-wire slave
// [R2] three-wire slave always drives miso from shift register msb
// [R3] both data lines shift most significant bit first
// [R4] unselected four-wire slave ignores all serial clock activity
// [R5] select mode 00: three-wire, pin unused, slave always selected
// [R6] select mode 01: pin is input, selects slave, low faults master
// [R7] upper select bit set: pin output equals lower select bit
// [R8] select pin routed to a package pin except in three-wire mode
// [R9] master data write fills transmit buffer, starts transfer when shifter empty
// [R10] master shifts mosi, captures miso, moves byte to receive buffer
// [R11] every byte end sets sticky done flag until software clears it
// [R12] multi-master select low clears master and enable, sets mode fault
// [R13] master when master bit set; otherwise enabled block is slave
// [R14] slave counts clock edges, after eight bits flags done and stores
// [R15] slave never starts; writes double-buffered into the shift register
// [R16] four-wire slave active while select low; select fall clears counter
// [R17] external master lowers select two clocks before first edge
// [R18] three-wire slave counter cleared only by disable and re-enable
// [R19] a three-wire slave bus carries no other slave
// [R20] data write while transmit buffer full flags collision, is dropped
// [R21] slave byte with unread receive buffer flags overrun, keeps old
// [R22] idle clock level follows polarity bit; phase picks sample edge
// [R23] master clock equals core clock over two times divider plus one
// [R24] master samples miso one core clock before the mosi change edge
`timescale 1ns/1ns
`include "smc_defines.svh"
module smc_spi_ctrl (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // avalon-mm register slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // serial clock pin
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  // master out slave in pin
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  // master in slave out pin
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  // select pin
  input  wire logic        nss_i,
  output logic             nss_o,
  output logic             nss_oe,
  output logic             nss_routed
);
  import smc_pkg::*;

  smc_gen_if gif ();

  // register state
  logic      en_r, mst_r, cpha_r, cpol_r;
  smc_sel_t  mode_r;
  logic      done_r, write_collision_flag_r, mode_fault_flag_r, ovrn_r;
  smc_byte_t div_r;

  // data path state
  smc_byte_t tx_buf_r, rx_buf_r, shreg_r;
  logic      tx_full_r, rx_full_r, sh_full_r;
  logic [3:0] cnt_r;
  logic      in_bit_r;
  logic      miso_d_r;
  logic      sck_q_r, nss_q_r, slv_sel_r;

  // bus outputs and pin enables
  logic [31:0] rdata_r;
  logic        wait_r;
  logic        sck_oe_r, mosi_oe_r, miso_oe_r;
  logic        nss_o_r, nss_oe_r, nss_routed_r;

  // bus decode
  wire        req     = avs_read | avs_write;
  wire        fire    = req & ~wait_r;
  wire        wr      = fire & avs_write & avs_byteenable[0];
  wire        rd      = fire & avs_read;
  wire        hit_ctl = avs_address == `SMC_OFS_CTL;
  wire        hit_cfg = avs_address == `SMC_OFS_CFG;
  wire        hit_dat = avs_address == `SMC_OFS_DAT;
  wire        hit_div = avs_address == `SMC_OFS_DIV;
  wire        wr_ctl  = wr & hit_ctl;
  wire        wr_cfg  = wr & hit_cfg;
  wire        wr_dat  = wr & hit_dat;
  wire        wr_div  = wr & hit_div;
  wire        rd_dat  = rd & hit_dat;
  wire [7:0]  wd      = avs_writedata[7:0];

  // role and select decode
  wire is_master  = en_r & mst_r;                                  // R13
  wire is_slave   = en_r & ~mst_r;                                 // R13
  wire three_wire = mode_r == SMC_SEL_3WIRE;
  wire slave_act  = is_slave & (three_wire | ~nss_i);    // R4 R5 R16
  wire mode_fault = is_master & (mode_r == SMC_SEL_4W_IN) & ~nss_i; // R6 R12
  wire nss_fall   = ~three_wire & nss_q_r & ~nss_i;                // R16

  // slave clock edges, judged against the idle level
  wire lead_edge  = (sck_q_r == cpol_r) & (sck_i != cpol_r);
  wire trail_edge = (sck_q_r != cpol_r) & (sck_i == cpol_r);
  wire samp_edge  = slave_act & (cpha_r ? trail_edge : lead_edge); // R22
  // the first shift edge of a byte is skipped so the msb stays on miso
  wire shf_edge   = slave_act & (cpha_r ? lead_edge : trail_edge)
                    & (cnt_r != 4'h0);
  wire slv_done   = samp_edge & (cnt_r == `SMC_LAST_BIT);          // R14
  wire mst_done   = is_master & gif.done_stb;

  // a byte always completes with its last bit still outside the shifter
  wire       last_in   = is_master ? miso_d_r : mosi_i;
  wire [7:0] rx_byte   = {shreg_r[6:0], last_in};                  // R3
  wire       byte_done = mst_done | slv_done;

  // transmit buffer to shifter transfer
  wire mst_load = is_master & tx_full_r & ~sh_full_r & ~gif.busy;  // R9
  wire slv_load = is_slave & tx_full_r
                  & (slv_done | (~sh_full_r & (cnt_r == 4'h0)
                                 & ~samp_edge));                   // R15
  wire load     = mst_load | slv_load;

  // data port write handling
  wire collide  = wr_dat & tx_full_r;                              // R20
  wire tx_take  = wr_dat & ~tx_full_r;

  // receive buffer handling
  wire overrun  = slv_done & rx_full_r;                            // R21
  wire rx_store = mst_done | (slv_done & ~rx_full_r);              // R10

  // status views
  wire busy_v   = gif.busy | (cnt_r != 4'h0);
  wire srmt_v   = is_master | ~sh_full_r;
  wire rxbmt_v  = is_master | ~rx_full_r;

  wire [7:0] ctl_v = {done_r, write_collision_flag_r, mode_fault_flag_r, ovrn_r, mode_r,
                      ~tx_full_r, en_r};
  wire [7:0] cfg_v = {busy_v, mst_r, cpha_r, cpol_r, slv_sel_r,
                      nss_i, srmt_v, rxbmt_v};
  wire [7:0] rsel  = hit_ctl ? ctl_v :
                     hit_cfg ? cfg_v :
                     hit_dat ? rx_buf_r :
                     hit_div ? div_r : 8'h00;

  // clock generator hookup
  assign gif.start = mst_load;                                     // R9
  assign gif.abort = ~is_master;
  assign gif.div   = div_r;                                        // R23
  assign gif.cpol  = cpol_r;
  assign gif.cpha  = cpha_r;

  smc_sck_gen u_gen (
    .core_clk (core_clk),
    .srst     (srst),
    .g        (gif.gen)
  );

  // bus handshake: one wait cycle, read data registered beside it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait_r  <= 1'b1;
      rdata_r <= `SMC_RST_RDATA;
    end else begin
      wait_r  <= ~(req & wait_r);
      rdata_r <= {24'h00_0000, rsel};
    end
  end

  // control register; a fault outranks a software enable
  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_r   <= 1'b0;
      mode_r <= smc_sel_t'(`SMC_RST_SEL);
    end else begin
      if (mode_fault) begin
        en_r <= 1'b0;                                              // R12
      end else if (wr_ctl) begin
        en_r <= wd[`SMC_CTL_EN];
      end
      if (wr_ctl) begin
        mode_r <= smc_sel_t'(wd[`SMC_CTL_SEL_HI:`SMC_CTL_SEL_LO]);
      end
    end
  end

  // sticky flags: writing 0 clears, writing 1 keeps, a new event wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      ovrn_r <= 1'b0;
    end else begin
      done_r <= byte_done                                          // R11
                | (done_r & (~wr_ctl | wd[`SMC_CTL_DONE]));
      write_collision_flag_r <= collide                                            // R20
                | (write_collision_flag_r & (~wr_ctl | wd[`SMC_CTL_WRITE_COLLISION_FLAG]));
      mode_fault_flag_r <= mode_fault                                         // R12
                | (mode_fault_flag_r & (~wr_ctl | wd[`SMC_CTL_MODE_FAULT_FLAG]));
      ovrn_r <= overrun                                            // R21
                | (ovrn_r & (~wr_ctl | wd[`SMC_CTL_OVRN]));
    end
  end

  // configuration and divider registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mst_r  <= 1'b0;
      cpha_r <= 1'b0;
      cpol_r <= 1'b0;
      div_r  <= `SMC_RST_DIV;
    end else begin
      if (mode_fault) begin
        mst_r <= 1'b0;                                             // R12
      end else if (wr_cfg) begin
        mst_r <= wd[`SMC_CFG_MST];
      end
      if (wr_cfg) begin
        cpha_r <= wd[`SMC_CFG_PHA];
        cpol_r <= wd[`SMC_CFG_POL];
      end
      if (wr_div) begin
        div_r <= wd;
      end
    end
  end

  // transmit buffer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_buf_r  <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (tx_take) begin
      tx_buf_r  <= wd;                                             // R9
      tx_full_r <= 1'b1;
    end else if (load) begin
      tx_full_r <= 1'b0;
    end
  end

  // receive buffer; a read in the same cycle as a store leaves it full
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_buf_r  <= 8'h00;
      rx_full_r <= 1'b0;
    end else if (rx_store) begin
      rx_buf_r  <= rx_byte;                                        // R10 R14
      rx_full_r <= 1'b1;
    end else if (rd_dat) begin
      rx_full_r <= 1'b0;
    end
  end

  // shift register, shared by both roles
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shreg_r <= 8'h00;
    end else if (load) begin
      shreg_r <= tx_buf_r;                                         // R15
    end else if (is_master & gif.shift_stb) begin
      shreg_r <= {shreg_r[6:0], miso_d_r};                         // R10 R3
    end else if (shf_edge) begin
      shreg_r <= {shreg_r[6:0], in_bit_r};                         // R3
    end
  end

  // shifter occupancy: a sampling edge of an active slave also marks it in use
  always_ff @(posedge core_clk) begin
    if (srst | ~en_r) begin
      sh_full_r <= 1'b0;
    end else if (load) begin
      sh_full_r <= 1'b1;
    end else if (byte_done) begin
      sh_full_r <= 1'b0;
    end else if (samp_edge) begin
      sh_full_r <= 1'b1;
    end
  end

  // slave bit counter; in three-wire mode only disabling clears it
  always_ff @(posedge core_clk) begin
    if (srst | ~en_r) begin
      cnt_r <= 4'h0;                                               // R18
    end else if (nss_fall) begin
      cnt_r <= 4'h0;                                               // R16
    end else if (samp_edge) begin
      cnt_r <= slv_done ? 4'h0 : cnt_r + 4'h1;                     // R14
    end
  end

  // pin history; miso_d_r holds the pin one clock back for the master
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sck_q_r   <= 1'b0;
      nss_q_r   <= 1'b1;
      slv_sel_r <= 1'b0;
      in_bit_r  <= 1'b0;
      miso_d_r  <= 1'b0;
    end else begin
      sck_q_r   <= sck_i;
      nss_q_r   <= nss_i;
      slv_sel_r <= ~nss_q_r;
      miso_d_r  <= miso_i;                                         // R24
      if (samp_edge) begin
        in_bit_r <= mosi_i;
      end
    end
  end

  // pin enables and select output
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sck_oe_r     <= 1'b0;
      mosi_oe_r    <= 1'b0;
      miso_oe_r    <= 1'b0;
      nss_o_r      <= 1'b1;
      nss_oe_r     <= 1'b0;
      nss_routed_r <= 1'b1;
    end else begin
      sck_oe_r     <= is_master;
      mosi_oe_r    <= is_master;
      miso_oe_r    <= slave_act;                                   // R1 R2
      nss_o_r      <= mode_r[0];                                   // R7
      nss_oe_r     <= mode_r[1];                                   // R7
      nss_routed_r <= ~three_wire;                                 // R8
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign sck_o           = gif.sck;                                // R22
  assign sck_oe          = sck_oe_r;
  assign mosi_o          = shreg_r[7];                             // R3
  assign mosi_oe         = mosi_oe_r;
  assign miso_o          = shreg_r[7];                             // R2 R3
  assign miso_oe         = miso_oe_r;
  assign nss_o           = nss_o_r;
  assign nss_oe          = nss_oe_r;
  assign nss_routed      = nss_routed_r;
endmodule : smc_spi_ctrl

//--- smc_spi_monitor.sv
// pin and register bus checks for the spi controller
// bound to every smc_spi_ctrl; sees only its ports
`timescale 1ns/1ns
module smc_spi_monitor (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins
  input wire logic        sck_oe,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        nss_i,
  input wire logic        nss_o,
  input wire logic        nss_oe,
  input wire logic        nss_routed
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd_done;
    avs_read && !avs_waitrequest;
  endsequence
  // nss must stay high long enough to pass any input synchroniser
  sequence s_unsel;
    $past(nss_i, 2) && $past(nss_i) && nss_i;
  endsequence

  a_wait_one: assert property (s_req |=> !avs_waitrequest)
    else $error("access not answered after one wait cycle");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property
    ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped without a request");
  a_rdata_upper: assert property
    (s_rd_done |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_unmapped_zero: assert property
    (s_rd_done ##0 (avs_address[1:0] != 2'h0) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_miso_unsel_off: assert property
    (s_unsel |=> !miso_oe || !nss_routed || nss_oe)
    else $error("unselected four-wire slave drives miso");
  a_role_excl: assert property
    (miso_oe |-> !mosi_oe && !sck_oe)
    else $error("slave and master drivers on together");
  a_master_pins: assert property (sck_oe == mosi_oe)
    else $error("master clock and data enables differ");
  a_sel_out: assert property (nss_oe |-> nss_routed)
    else $error("select driven but not routed");
  a_unrouted_sel: assert property
    (!nss_routed |-> !nss_oe && !nss_o)
    else $error("three-wire mode touches select pin");
  a_fault_drop: assert property
    (sck_oe && !nss_i && nss_routed && !nss_oe |-> ##[1:6] !sck_oe)
    else $error("select low did not end master role");
endmodule : smc_spi_monitor

bind smc_spi_ctrl smc_spi_monitor smc_spi_monitor_i (
  .core_clk(core_clk), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .nss_i(nss_i),
  .nss_o(nss_o), .nss_oe(nss_oe), .nss_routed(nss_routed));

//--- smc_far_slave.sv
// far-side spi slave: idle-low clock, samples rising, shifts falling
// the bench reloads it with load only between frames
`timescale 1ns/1ns
module smc_far_slave (
  // serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // bench side
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  logic [7:0] shf_r;
  logic [7:0] rx_r;
  assign miso    = shf_r[7];
  assign rx_byte = rx_r;
  always @(posedge sck) rx_r <= {rx_r[6:0], mosi};
  // one process owns the shifter; a load pulse wins over a clock edge
  // spent bits refill with a toggling pattern so stale data never passes
  always @(posedge load or negedge sck) begin
    if (load) begin
      shf_r <= tx_byte;
    end else begin
      shf_r <= {shf_r[6:0], ~shf_r[0]};
    end
  end
endmodule : smc_far_slave

//--- smc_tb.sv
// self-checking bench for smc_spi_ctrl with one far-side slave
// bench plays avalon master and, in slave tests, the spi master
`timescale 1ns/1ns
module tb;
  logic        core_clk;
  logic        srst;
  logic [3:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [31:0] rd_q;
  wire  [31:0] avs_rdata;
  wire         wait_rq;
  wire         sck_m, sck_oe, mosi_m, mosi_oe, miso_s, miso_oe;
  wire         nss_o, nss_oe, nss_rt, far_miso;
  wire  [7:0]  far_rx;
  logic        tb_sck, tb_mosi, tb_nss, ld;
  logic [7:0]  far_tx;
  logic [7:0]  got;
  int          error_cnt, total_checks, cyc;
  wire         sck_w  = sck_oe ? sck_m : tb_sck;
  wire         mosi_w = mosi_oe ? mosi_m : tb_mosi;
  wire         miso_w = miso_oe ? miso_s : far_miso;
  wire         nss_w  = nss_oe ? nss_o : tb_nss;

  smc_spi_ctrl smc_spi_ctrl_i (
    .core_clk(core_clk), .srst(srst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
    .avs_readdata(avs_rdata), .avs_waitrequest(wait_rq),
    .sck_i(sck_w), .sck_o(sck_m), .sck_oe(sck_oe), .mosi_i(mosi_w),
    .mosi_o(mosi_m), .mosi_oe(mosi_oe), .miso_i(miso_w),
    .miso_o(miso_s), .miso_oe(miso_oe), .nss_i(nss_w), .nss_o(nss_o),
    .nss_oe(nss_oe), .nss_routed(nss_rt));
  // sole slave on the bus, so three-wire mode stays legal
  smc_far_slave smc_far_slave_i (
    .sck(sck_w), .mosi(mosi_w), .miso(far_miso), .load(ld),
    .tx_byte(far_tx), .rx_byte(far_rx));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end

  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e,
                          input string m);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : cmp_byte

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    rd   <= ~w;
    wr   <= w;
    adr  <= a;
    wdat <= {24'h00_0000, d};
    do @(posedge core_clk); while (wait_rq !== 1'b0);
    rd_q = avs_rdata;
    rd   <= 1'b0;
    wr   <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wreg

  task automatic creg(input logic [3:0] a, input logic [7:0] e,
                      input logic [7:0] msk);
    bus(1'b0, a, 8'h00);
    cmp_byte(rd_q[7:0] & msk, e, "register");
  endtask : creg

  task automatic wait_done;
    rd_q = 32'h0;
    for (int i = 0; i < 200 && rd_q[7] !== 1'b1; i++) begin
      bus(1'b0, 4'h0, 8'h00);
    end
  endtask : wait_done

  task automatic pins(input logic [7:0] e);
    repeat (2) @(posedge core_clk);
    cmp_byte({4'h0, nss_rt, nss_oe, nss_o, miso_oe}, e, "pins");
  endtask : pins

  // bench as spi master, mode 0, select low well ahead of the clock
  task automatic sbyte(input logic [7:0] d);
    tb_nss <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 7; i >= 0; i--) begin
      tb_mosi <= d[i];
      repeat (3) @(posedge core_clk);
      got[i] = miso_w;
      tb_sck <= 1'b1;
      repeat (3) @(posedge core_clk);
      tb_sck <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    tb_nss <= 1'b1;
  endtask : sbyte

  task automatic t_reset;
    creg(4'h0, 8'h06, 8'hFF);
    creg(4'h4, 8'h07, 8'hFF);
    creg(4'hC, 8'h00, 8'hFF);
    creg(4'h2, 8'h00, 8'hFF);
    pins(8'h0A);
  endtask : t_reset

  task automatic t_master;
    int n;
    wreg(4'h4, 8'h40);
    wreg(4'hC, 8'h01);
    wreg(4'h0, 8'h0D);
    pins(8'h0E);
    cmp_byte({7'h00, sck_oe}, 8'h01, "sck_oe");
    far_tx <= 8'h3C;
    ld <= 1'b1;
    @(posedge core_clk);
    ld <= 1'b0;
    wreg(4'h8, 8'hA5);
    wait (sck_m === 1'b1);
    n = 0;
    @(posedge core_clk);
    while (sck_m === 1'b1) begin
      n++;
      @(posedge core_clk);
    end
    // divider 1 gives a half period of two core clocks
    cmp_byte(n[7:0], 8'h02, "half period");
    wait_done;
    cmp_byte(far_rx, 8'hA5, "mosi byte");
    creg(4'h8, 8'h3C, 8'hFF);
    cmp_byte({7'h00, sck_m}, 8'h00, "sck idle");
  endtask : t_master

  task automatic t_collide;
    wreg(4'h0, 8'h0D);
    wreg(4'h8, 8'h11);
    wreg(4'h8, 8'h22);
    wreg(4'h8, 8'h33);
    creg(4'h0, 8'h40, 8'h42);
    wait_done;
    wreg(4'h0, 8'h0D);
    wait_done;
    cmp_byte(far_rx, 8'h22, "kept byte");
  endtask : t_collide

  // master in phase 1 with an idle-high clock; the far slave still
  // samples on rising edges, which are the trailing ones here
  task automatic t_mode3;
    wreg(4'h4, 8'h70);
    wreg(4'h0, 8'h0D);
    cmp_byte({7'h00, sck_m}, 8'h01, "sck idle high");
    wreg(4'h8, 8'h69);
    wait_done;
    cmp_byte(far_rx, 8'h69, "phase 1 byte");
    cmp_byte({7'h00, sck_m}, 8'h01, "sck idle after");
    // master bytes fill the receive buffer; drain it so slave tests
    // start without a pending byte, then restore mode 0
    bus(1'b0, 4'h8, 8'h00);
    wreg(4'h4, 8'h40);
  endtask : t_mode3

  task automatic t_fault;
    wreg(4'h0, 8'h05);
    tb_nss <= 1'b0;
    repeat (8) @(posedge core_clk);
    creg(4'h0, 8'h20, 8'h21);
    creg(4'h4, 8'h00, 8'h40);
    cmp_byte({7'h00, sck_oe}, 8'h00, "sck_oe");
    tb_nss <= 1'b1;
  endtask : t_fault

  task automatic t_slave;
    wreg(4'h0, 8'h05);
    wreg(4'h8, 8'h96);
    pins(8'h0A);
    sbyte(8'h5A);
    cmp_byte(got, 8'h96, "miso byte");
    creg(4'h0, 8'h80, 8'h90);
    sbyte(8'hC3);
    creg(4'h0, 8'h90, 8'h90);
    creg(4'h8, 8'h5A, 8'hFF);
    creg(4'h4, 8'h01, 8'h01);
  endtask : t_slave

  task automatic t_3wire;
    wreg(4'h0, 8'h01);
    pins(8'h01);
    wreg(4'h0, 8'h00);
    pins(8'h00);
  endtask : t_3wire

  initial begin
    srst = 1'b1;
    {rd, wr, adr, wdat, tb_sck, tb_mosi, ld, far_tx} = '0;
    tb_nss = 1'b1;
    cyc = 0;
    error_cnt = 0;
    total_checks = 0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    t_reset;
    t_master;
    t_collide;
    t_mode3;
    t_fault;
    t_slave;
    t_3wire;
    print_verdict;
  end
endmodule : tb
